// ===== logic/acsd_pkg.sv
package acsd_pkg;

  localparam int SHIFT_W = 9;
  localparam int FUNC_W = 3;
  localparam int SET_W = 6;
  localparam int ADDR_BITS = 2;
  localparam logic [1:0] DEV_ADDR = 2'h2;
  localparam logic [5:0] LATCH_RESET = 6'h00;
  localparam logic [3:0] MIN_BITS = 4'hb;

  localparam logic [2:0] OFF_INPUT_SEL = 3'h0;
  localparam logic [2:0] OFF_BASS = 3'h1;
  localparam logic [2:0] OFF_TREBLE = 3'h2;
  localparam logic [2:0] OFF_VOLUME = 3'h3;
  localparam logic [2:0] OFF_RIGHT_FRONT = 3'h4;
  localparam logic [2:0] OFF_LEFT_FRONT = 3'h5;
  localparam logic [2:0] OFF_RIGHT_REAR = 3'h6;
  localparam logic [2:0] OFF_LEFT_REAR = 3'h7;

  localparam int FADER_LVL_W = 5;
  localparam int TONE_LVL_W = 4;
  localparam int SRC_W = 3;
  localparam int SRC_RSV_BIT = 3;
  localparam logic [5:0] VOL_MAX = 6'h29;
  localparam logic [4:0] FADER_MAX = 5'h15;
  localparam logic [3:0] TONE_MAX = 4'hc;
  localparam logic [2:0] SRC_MAX = 3'h4;

  typedef struct packed {
    logic [2:0] func;
    logic [5:0] setting;
  } acsd_word_s;

  typedef struct packed {
    logic [5:0] master_volume;
    logic [3:0] treble_level;
    logic [3:0] bass_level;
    logic [4:0] right_front;
    logic [4:0] left_front;
    logic [4:0] right_rear;
    logic [4:0] left_rear;
    logic [2:0] source;
  } acsd_levels_s;

endpackage

// ===== logic/acsd_sync.sv
`timescale 1ns/100ps
// two flip-flop level synchroniser
module acsd_sync #(
  parameter logic INIT = 1'b0
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic en,
  input wire logic din,
  output logic dout
);

  logic meta;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      meta <= INIT;
      dout <= INIT;
    end
    else if (en)
    begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule // acsd_sync

// ===== logic/acsd_decoder.sv
`timescale 1ns/100ps
// Operation
// - shift data on each bus clock rise
// - first two bits are address 1,0
// - wrong address: ignore transfer, keep latches
// - keep only last nine bits
// - enable rise stops shift, loads latch
// - settings change only at latch load
// - three function bits, six setting bits
// - function code selects one of eight latches
// - faders use low five bits
// - volume uses all six bits
// - tone uses low four bits
// - input select uses low three bits and reserved bit 3
// - one code step is 2 dB
// - enable low activates bus
module acsd_decoder (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic bus_clk,
  input wire logic bus_data,
  input wire logic bus_enable_n,
  output logic [5:0] input_selector_latch,
  output logic [5:0] bass_level_latch,
  output logic [5:0] treble_level_latch,
  output logic [5:0] master_volume_latch,
  output logic [5:0] right_front_attenuation,
  output logic [5:0] left_front_attenuation,
  output logic [5:0] right_rear_attenuation,
  output logic [5:0] left_rear_attenuation,
  output acsd_pkg::acsd_levels_s levels,
  output logic load_pulse
);

  // link domain: bus_clk is the clock; the frame is bounded by enable.
  // enable high acts as an asynchronous clear of the frame state so a new
  // frame always starts in address decode even though bus_clk is idle
  // between frames.
  logic [1:0] addr_sr;
  logic [1:0] addr_cnt;
  logic addr_ok;
  logic [3:0] bit_cnt;
  logic [8:0] shift_sr;
  logic frame_good;

  always_ff @(posedge bus_clk or posedge bus_enable_n)
  begin
    if (bus_enable_n)
    begin
      addr_cnt <= 2'h0;
      addr_sr <= 2'h0;
      addr_ok <= 1'b0;
      bit_cnt <= 4'h0;
    end
    else
    begin
      if (addr_cnt != 2'(acsd_pkg::ADDR_BITS))
      begin
        addr_sr <= {addr_sr[0], bus_data};
        addr_cnt <= addr_cnt + 2'h1;
      end
      if (bit_cnt != acsd_pkg::MIN_BITS)
        bit_cnt <= bit_cnt + 4'h1;
      if (addr_cnt == 2'(acsd_pkg::ADDR_BITS))
        addr_ok <= (addr_sr == acsd_pkg::DEV_ADDR);
    end
  end

  // data shifting does not need a clear: only the last nine bits matter
  always_ff @(posedge bus_clk)
  begin
    if (!bus_enable_n)
      shift_sr <= {shift_sr[7:0], bus_data};
  end

  // frame verdict computed combinationally; it is stable once bus_clk stops
  // and enable rises, and the main domain samples the snapshot only after
  // seeing the synchronised rise, so data has had two cycles to settle.
  assign frame_good = addr_ok && (bit_cnt == acsd_pkg::MIN_BITS);

  // snapshot captured on enable rise, held across idle time
  logic [8:0] snap_word;
  logic snap_good;

  always_ff @(posedge bus_enable_n)
  begin
    snap_word <= shift_sr;
    snap_good <= frame_good;
  end

  // main domain: synchronise enable level, detect its rise
  logic en_n_sync;
  logic en_n_prev;
  logic en_rise;

  acsd_sync #(.INIT(1'b1)) u_en_sync (
    .clk(clk),
    .nrst(nrst),
    .en(ce),
    .din(bus_enable_n),
    .dout(en_n_sync)
  );

  always_ff @(posedge clk)
  begin
    if (!nrst)
      en_n_prev <= 1'b1;
    else if (ce)
      en_n_prev <= en_n_sync;
  end

  assign en_rise = en_n_sync && !en_n_prev;

  acsd_pkg::acsd_word_s word;
  assign word = acsd_pkg::acsd_word_s'(snap_word);

  always_ff @(posedge clk)
  begin
    if (!nrst)
      load_pulse <= 1'b0;
    else if (ce)
      load_pulse <= en_rise && snap_good;
  end

  // latches only change on a load, once per good frame
  logic [7:0] latch_sel;
  logic load_now;

  assign load_now = ce && en_rise && snap_good;

  // one-hot select of the addressed latch
  always_comb
  begin
    latch_sel = 8'h00;
    unique case (word.func)
      acsd_pkg::OFF_INPUT_SEL: latch_sel = 8'h01;
      acsd_pkg::OFF_BASS: latch_sel = 8'h02;
      acsd_pkg::OFF_TREBLE: latch_sel = 8'h04;
      acsd_pkg::OFF_VOLUME: latch_sel = 8'h08;
      acsd_pkg::OFF_RIGHT_FRONT: latch_sel = 8'h10;
      acsd_pkg::OFF_LEFT_FRONT: latch_sel = 8'h20;
      acsd_pkg::OFF_RIGHT_REAR: latch_sel = 8'h40;
      acsd_pkg::OFF_LEFT_REAR: latch_sel = 8'h80;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      input_selector_latch <= acsd_pkg::LATCH_RESET;
    else if (load_now && latch_sel[0])
      input_selector_latch <= word.setting;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      bass_level_latch <= acsd_pkg::LATCH_RESET;
    else if (load_now && latch_sel[1])
      bass_level_latch <= word.setting;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      treble_level_latch <= acsd_pkg::LATCH_RESET;
    else if (load_now && latch_sel[2])
      treble_level_latch <= word.setting;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      master_volume_latch <= acsd_pkg::LATCH_RESET;
    else if (load_now && latch_sel[3])
      master_volume_latch <= word.setting;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      right_front_attenuation <= acsd_pkg::LATCH_RESET;
    else if (load_now && latch_sel[4])
      right_front_attenuation <= word.setting;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      left_front_attenuation <= acsd_pkg::LATCH_RESET;
    else if (load_now && latch_sel[5])
      left_front_attenuation <= word.setting;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      right_rear_attenuation <= acsd_pkg::LATCH_RESET;
    else if (load_now && latch_sel[6])
      right_rear_attenuation <= word.setting;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      left_rear_attenuation <= acsd_pkg::LATCH_RESET;
    else if (load_now && latch_sel[7])
      left_rear_attenuation <= word.setting;
  end

  // decoded level steps, each unit is one 2 dB step; out of range codes
  // are clamped so the analog side never sees an undefined step
  function automatic logic [5:0] clamp6(input logic [5:0] v,
                                        input logic [5:0] m);
    clamp6 = (v > m) ? m : v;
  endfunction

  logic [5:0] vol_step;
  logic [3:0] treble_step;
  logic [3:0] bass_step;
  logic [4:0] rf_step;
  logic [4:0] lf_step;
  logic [4:0] rr_step;
  logic [4:0] lr_step;
  logic [2:0] src_step;

  always_ff @(posedge clk)
  begin
    if (!nrst)
      vol_step <= 6'h00;
    else if (ce)
      vol_step <= clamp6(master_volume_latch,
        acsd_pkg::VOL_MAX);
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      treble_step <= 4'h0;
    else if (ce)
      treble_step <= 4'(clamp6({2'h0, treble_level_latch[3:0]},
        {2'h0, acsd_pkg::TONE_MAX}));
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      bass_step <= 4'h0;
    else if (ce)
      bass_step <= 4'(clamp6({2'h0, bass_level_latch[3:0]},
        {2'h0, acsd_pkg::TONE_MAX}));
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      rf_step <= 5'h00;
    else if (ce)
      rf_step <= 5'(clamp6({1'b0, right_front_attenuation[4:0]},
        {1'b0, acsd_pkg::FADER_MAX}));
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      lf_step <= 5'h00;
    else if (ce)
      lf_step <= 5'(clamp6({1'b0, left_front_attenuation[4:0]},
        {1'b0, acsd_pkg::FADER_MAX}));
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      rr_step <= 5'h00;
    else if (ce)
      rr_step <= 5'(clamp6({1'b0, right_rear_attenuation[4:0]},
        {1'b0, acsd_pkg::FADER_MAX}));
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      lr_step <= 5'h00;
    else if (ce)
      lr_step <= 5'(clamp6({1'b0, left_rear_attenuation[4:0]},
        {1'b0, acsd_pkg::FADER_MAX}));
  end

  // a set reserved bit selects open, as does any code above four
  always_ff @(posedge clk)
  begin
    if (!nrst)
      src_step <= 3'h0;
    else if (ce)
    begin
      if (input_selector_latch[acsd_pkg::SRC_RSV_BIT])
        src_step <= 3'h0;
      else if (input_selector_latch[2:0] > acsd_pkg::SRC_MAX)
        src_step <= 3'h0;
      else
        src_step <= input_selector_latch[2:0];
    end
  end

  assign levels = acsd_pkg::acsd_levels_s'({vol_step, treble_step,
    bass_step, rf_step, lf_step, rr_step, lr_step, src_step});

endmodule // acsd_decoder

// ===== dv/acsd_decoder_props.sv
`timescale 1ns/100ps
module acsd_decoder_chk (
  input wire logic clk,
  input wire logic nrst,
  input wire logic bus_enable_n,
  input wire logic [5:0] input_selector_latch,
  input wire logic [5:0] bass_level_latch,
  input wire logic [5:0] treble_level_latch,
  input wire logic [5:0] master_volume_latch,
  input wire logic [5:0] right_front_attenuation,
  input wire logic [5:0] left_front_attenuation,
  input wire logic [5:0] right_rear_attenuation,
  input wire logic [5:0] left_rear_attenuation,
  input wire acsd_pkg::acsd_levels_s levels,
  input wire logic load_pulse
);
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  a_pulse_single: assert property (load_pulse |=> !load_pulse)
    else $error("load pulse wider than one cycle");
  a_load_after_enable: assert property (load_pulse |->
    bus_enable_n && $past(bus_enable_n, 2))
    else $error("load while enable low");
  a_latch_hold: assert property ($changed({input_selector_latch,
    bass_level_latch, treble_level_latch, master_volume_latch,
    right_front_attenuation, left_front_attenuation,
    right_rear_attenuation, left_rear_attenuation}) |-> load_pulse)
    else $error("latch moved without load");
  a_levels_follow: assert property ($changed(levels) |-> $past(load_pulse))
    else $error("levels moved without load");
  a_volume_step: assert property (load_pulse |=>
    levels.master_volume == (master_volume_latch > 6'h29 ? 6'h29 :
    master_volume_latch))
    else $error("volume step wrong");
  a_tone_step: assert property (load_pulse |=>
    levels.treble_level == (treble_level_latch[3:0] > 4'hc ? 4'hc :
    treble_level_latch[3:0]))
    else $error("treble step wrong");
  a_fader_step: assert property (load_pulse |=>
    levels.left_rear == (left_rear_attenuation[4:0] > 5'h15 ? 5'h15 :
    left_rear_attenuation[4:0]))
    else $error("fader step wrong");
  a_source_pick: assert property (load_pulse |=> levels.source ==
    ((input_selector_latch[3] || input_selector_latch[2:0] > 3'h4) ?
    3'h0 : input_selector_latch[2:0]))
    else $error("source pick wrong");
endmodule // acsd_decoder_chk
bind acsd_decoder acsd_decoder_chk acsd_decoder_chk_i (.*);

// ===== dv/acsd_bus_host.sv
`timescale 1ns/100ps
module acsd_bus_host (
  output logic bus_clk,
  output logic bus_data,
  output logic bus_enable_n
);
  initial
  begin
    bus_clk = 1'b0;
    bus_data = 1'b0;
    bus_enable_n = 1'b1;
  end
  // clock idles low between frames, so enable always falls with it low
  task automatic send(input logic [15:0] bits, input int n);
    bus_enable_n = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      bus_data = bits[i];
      #40;
      bus_clk = 1'b1;
      #40;
      bus_clk = 1'b0;
    end
    #20;
    bus_enable_n = 1'b1;
    // undriven data must not look like the last bit
    bus_data = ~bus_data;
  endtask
endmodule // acsd_bus_host

// ===== dv/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic clk;
  logic nrst;
  logic bus_clk;
  logic bus_data;
  logic bus_enable_n;
  logic [5:0] lat [8];
  logic [5:0] exp_lat [8];
  acsd_pkg::acsd_levels_s levels;
  logic load_pulse;
  int n_fail;
  int check_count;
  int cyc;
  acsd_bus_host acsd_bus_host_i (.bus_clk(bus_clk), .bus_data(bus_data),
    .bus_enable_n(bus_enable_n));
  acsd_decoder acsd_decoder_i (.clk(clk), .nrst(nrst), .ce(1'b1),
    .bus_clk(bus_clk), .bus_data(bus_data), .bus_enable_n(bus_enable_n),
    .input_selector_latch(lat[0]), .bass_level_latch(lat[1]),
    .treble_level_latch(lat[2]), .master_volume_latch(lat[3]),
    .right_front_attenuation(lat[4]), .left_front_attenuation(lat[5]),
    .right_rear_attenuation(lat[6]), .left_rear_attenuation(lat[7]),
    .levels(levels), .load_pulse(load_pulse));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [5:0] got, input logic [5:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // refused frames wait the full window so a late load is still caught
  task automatic frame(input logic [15:0] b, input int n, input logic ok);
    logic hit;
    hit = 1'b0;
    @(posedge clk);
    #1;
    acsd_bus_host_i.send(b, n);
    for (int w = 0; w < 20 && hit !== 1'b1; w++)
    begin
      @(posedge clk);
      #1;
      hit = load_pulse;
    end
    check({5'h00, hit}, {5'h00, ok});
    if (ok)
      exp_lat[b[8:6]] = b[5:0];
    repeat (4) @(posedge clk);
    for (int i = 0; i < 8; i++)
      check(lat[i], exp_lat[i]);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      give_verdict();
    end
  end
  initial
  begin
    nrst = 1'b0;
    for (int i = 0; i < 8; i++)
      exp_lat[i] = 6'h00;
    repeat (16) @(posedge clk);
    #1 nrst = 1'b1;
    for (int i = 0; i < 8; i++)
      frame({7'h02, 3'(i), 6'(6'h21 + i * 2)}, 11, 1'b1);
    check({2'h0, levels.treble_level}, 6'h05);
    check({2'h0, levels.bass_level}, 6'h03);
    check({1'b0, levels.right_front}, 6'h09);
    check({1'b0, levels.left_front}, 6'h0b);
    check({1'b0, levels.right_rear}, 6'h0d);
    check({1'b0, levels.left_rear}, 6'h0f);
    check(levels.master_volume, 6'h27);
    $display("test functions done");
    frame(16'h06ff, 11, 1'b0);
    frame(16'h0233, 10, 1'b0);
    $display("test refusals done");
    frame(16'h2ae9, 14, 1'b1);
    check(levels.master_volume, 6'h29);
    check({3'h0, levels.source}, 6'h01);
    $display("test long frame done");
    frame({7'h02, 3'h3, 6'h00}, 11, 1'b1);
    frame({7'h02, 3'h0, 6'h00}, 11, 1'b1);
    check(levels.master_volume, 6'h00);
    check({3'h0, levels.source}, 6'h00);
    $display("test mute done");
    give_verdict();
  end
endmodule // testbench
